// File: dmacf_consts.svh
`ifndef DMACF_CONSTS_SVH
`define DMACF_CONSTS_SVH

// ----------------------------------------------------------------
// Register decode
// ----------------------------------------------------------------
`define DMACF_PAGE        8'h02
`define DMACF_ADDR_ENABLE 8'hD2
`define DMACF_ADDR_FULL   8'hD3
`define DMACF_ADDR_HALF   8'hD4

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DMACF_CFG_FULL_IE 7
`define DMACF_CFG_HALF_IE 6
`define DMACF_SEL_INVALID 3'h7
`define DMACF_REG_RESET   8'h00
`define DMACF_RDATA_IDLE  8'h00
`define DMACF_NUM_CH      7
`define DMACF_OFS_W       10

`endif

// File: dmacf_pkg.sv
package dmacf_pkg;

	// ----------------------------------------------------------------
	// Special-function-register access from the core
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0] page;
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dmacf_sfr_s;

endpackage : dmacf_pkg

// File: dmacf_chan_match.sv
module dmacf_chan_match
#(
	parameter int OFS_W = 10
)
(
	// Channel counters
	input  wire logic [OFS_W-1:0] offset_in,
	input  wire logic [OFS_W-1:0] size_in,
	// Compare results
	output logic                  full_hit_out,
	output logic                  half_hit_out
);
	localparam logic [OFS_W-1:0] ONE = OFS_W'(1);

	logic [OFS_W-1:0] half_target;

	// Odd sizes round the midpoint up by one
	assign half_target  = (size_in >> 1) + OFS_W'(size_in[0]);
	assign half_hit_out = (offset_in == half_target);
	// Size zero wraps to all ones and never matches a legal offset
	assign full_hit_out = (offset_in == (size_in - ONE));

endmodule : dmacf_chan_match

// File: dmacf_top.sv
`include "dmacf_consts.svh"

module dmacf_top
	import dmacf_pkg::*;
#(
	parameter int NUM_CH = `DMACF_NUM_CH,
	parameter int OFS_W  = `DMACF_OFS_W
)
(
	// Clock and reset
	input  wire logic                    clock_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    ce_in,
	// Register access
	input  wire dmacf_sfr_s              sfr_in,
	output logic [7:0]                   sfr_rdata_out,
	// Channel configuration writes
	input  wire logic                    cfg_wr_in,
	input  wire logic [2:0]              chan_select_field_in,
	input  wire logic [7:0]              cfg_wdata_in,
	// Channel progress
	input  wire logic [NUM_CH-1:0]       byte_done_in,
	input  wire logic [NUM_CH*OFS_W-1:0] chan_byte_offset_in,
	input  wire logic [NUM_CH*OFS_W-1:0] chan_transfer_size_in,
	// Channel control and requests
	output logic [NUM_CH-1:0]            chan_enable_out,
	output logic [NUM_CH-1:0]            chan_run_out,
	output logic [NUM_CH-1:0]            full_irq_out,
	output logic [NUM_CH-1:0]            half_irq_out
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic              page_hit;
	logic              wr_enable;
	logic              wr_full;
	logic              wr_half;
	logic [NUM_CH-1:0] channel_enable_reg;
	logic [NUM_CH-1:0] full_length_flag_reg;
	logic [NUM_CH-1:0] midpoint_flag_reg;
	logic [NUM_CH-1:0] full_ie;
	logic [NUM_CH-1:0] half_ie;
	logic [NUM_CH-1:0] full_hit;
	logic [NUM_CH-1:0] half_hit;
	logic [NUM_CH-1:0] full_set;
	logic [NUM_CH-1:0] half_set;
	logic [NUM_CH-1:0] next_full;
	logic [NUM_CH-1:0] next_half;
	logic [NUM_CH-1:0] wbits;
	logic [7:0]        next_rdata;

	assign page_hit  = (sfr_in.page == `DMACF_PAGE);
	assign wr_enable = sfr_in.wr && page_hit && (sfr_in.addr == `DMACF_ADDR_ENABLE);
	assign wr_full   = sfr_in.wr && page_hit && (sfr_in.addr == `DMACF_ADDR_FULL);
	assign wr_half   = sfr_in.wr && page_hit && (sfr_in.addr == `DMACF_ADDR_HALF);
	// Bit 7 never reaches storage
	assign wbits     = sfr_in.wdata[NUM_CH-1:0];

	// ----------------------------------------------------------------
	// Per-channel compare
	// ----------------------------------------------------------------
	// The offset is owned by the data mover; it is sampled on the
	// byte strobe, so each offset value is seen exactly once.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			dmacf_chan_match #(
				.OFS_W (OFS_W)
			) u_match (
				.offset_in    (chan_byte_offset_in[g*OFS_W +: OFS_W]),
				.size_in      (chan_transfer_size_in[g*OFS_W +: OFS_W]),
				.full_hit_out (full_hit[g]),
				.half_hit_out (half_hit[g])
			);
		end
	endgenerate

	assign full_set = full_hit & byte_done_in;
	assign half_set = half_hit & byte_done_in;

	// ----------------------------------------------------------------
	// Enable register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			channel_enable_reg <= NUM_CH'(`DMACF_REG_RESET);
		else if (ce_in && wr_enable)
			channel_enable_reg <= wbits;
	end

	// ----------------------------------------------------------------
	// Flag registers
	// ----------------------------------------------------------------
	// Hardware set is ORed after the write so a same-cycle write never clears it
	assign next_full = (wr_full ? wbits : full_length_flag_reg) | full_set;
	assign next_half = (wr_half ? wbits : midpoint_flag_reg) | half_set;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			full_length_flag_reg <= NUM_CH'(`DMACF_REG_RESET);
		else if (ce_in)
			full_length_flag_reg <= next_full;
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			midpoint_flag_reg <= NUM_CH'(`DMACF_REG_RESET);
		else if (ce_in)
			midpoint_flag_reg <= next_half;
	end

	// ----------------------------------------------------------------
	// Interrupt enables from the channel configuration
	// ----------------------------------------------------------------
	// Shadow of config bits 7:6 kept per channel; invalid code dropped
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			full_ie <= NUM_CH'(`DMACF_REG_RESET);
			half_ie <= NUM_CH'(`DMACF_REG_RESET);
		end
		else if (ce_in && cfg_wr_in && chan_select_field_in != `DMACF_SEL_INVALID)
		begin
			full_ie[chan_select_field_in] <= cfg_wdata_in[`DMACF_CFG_FULL_IE];
			half_ie[chan_select_field_in] <= cfg_wdata_in[`DMACF_CFG_HALF_IE];
		end
	end

	assign full_irq_out    = full_length_flag_reg & full_ie;
	assign half_irq_out    = midpoint_flag_reg & half_ie;
	assign chan_enable_out = channel_enable_reg;
	// Pending flags hold the channel until software clears them
	assign chan_run_out    = channel_enable_reg
		& ~(full_length_flag_reg | midpoint_flag_reg);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = `DMACF_RDATA_IDLE;
		if (page_hit)
		begin
			unique case (sfr_in.addr)
				`DMACF_ADDR_ENABLE: next_rdata = 8'(channel_enable_reg);
				`DMACF_ADDR_FULL:   next_rdata = 8'(full_length_flag_reg);
				`DMACF_ADDR_HALF:   next_rdata = 8'(midpoint_flag_reg);
				default:            next_rdata = `DMACF_RDATA_IDLE;
			endcase
		end
	end

	// Registered so the core sees a stable byte one cycle after the strobe
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sfr_rdata_out <= `DMACF_RDATA_IDLE;
		else if (ce_in && sfr_in.rd)
			sfr_rdata_out <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	chk_enable_write: assert property (
		(ce_in && wr_enable) |=> (chan_enable_out == $past(wbits)))
		else $error("enable register did not take written value");

	chk_bit7_zero: assert property (
		sfr_rdata_out[7] == 1'b0)
		else $error("bit 7 of read data not zero");

	chk_full_set: assert property (
		(ce_in && full_set != '0)
		|=> ((full_length_flag_reg & $past(full_set)) == $past(full_set)))
		else $error("full flag not set on final byte");

	chk_half_set: assert property (
		(ce_in && half_set != '0 && wr_half)
		|=> ((midpoint_flag_reg & $past(half_set)) == $past(half_set)))
		else $error("midpoint set lost against clear");

	chk_flag_sticky: assert property (
		!(ce_in && (wr_full || wr_half))
		|=> ((full_length_flag_reg & $past(full_length_flag_reg))
			== $past(full_length_flag_reg))
		&& ((midpoint_flag_reg & $past(midpoint_flag_reg))
			== $past(midpoint_flag_reg)))
		else $error("flag dropped without software write");

	chk_clear_write: assert property (
		(ce_in && wr_full && full_set == '0)
		|=> (full_length_flag_reg == $past(wbits)))
		else $error("full flag write not applied");

	chk_full_gate: assert property (
		(ce_in && cfg_wr_in && chan_select_field_in != `DMACF_SEL_INVALID)
		|=> (full_irq_out[$past(chan_select_field_in)]
			== (full_length_flag_reg[$past(chan_select_field_in)]
			&& $past(cfg_wdata_in[`DMACF_CFG_FULL_IE]))))
		else $error("full interrupt gate mismatch");

	chk_half_gate: assert property (
		(ce_in && cfg_wr_in && chan_select_field_in != `DMACF_SEL_INVALID)
		|=> (half_irq_out[$past(chan_select_field_in)]
			== (midpoint_flag_reg[$past(chan_select_field_in)]
			&& $past(cfg_wdata_in[`DMACF_CFG_HALF_IE]))))
		else $error("midpoint interrupt gate mismatch");

	chk_sel_invalid: assert property (
		(cfg_wr_in && chan_select_field_in == `DMACF_SEL_INVALID)
		|=> ($stable(full_ie) && $stable(half_ie)))
		else $error("invalid channel code changed enables");

	chk_run_hold: assert property (
		(ce_in && full_set != '0)
		|=> ((chan_run_out & $past(full_set)) == '0)[*2])
		else $error("channel runs with flag pending");

	chk_page_decode: assert property (
		(sfr_in.wr && !page_hit && byte_done_in == '0 && !cfg_wr_in)
		|=> ($stable(chan_enable_out) && $stable(full_length_flag_reg)
			&& $stable(midpoint_flag_reg)))
		else $error("write off page changed a register");

	chk_read_flags: assert property (
		(ce_in && sfr_in.rd && page_hit && sfr_in.addr == `DMACF_ADDR_FULL)
		|=> (sfr_rdata_out == 8'($past(full_length_flag_reg))))
		else $error("full flag read mismatch");

endmodule : dmacf_top

// File: dmacf_mover.sv
// ----------------------------------------------------------------
// Channel data mover stand-in
// ----------------------------------------------------------------
module dmacf_mover
#(
	parameter int OFS_W = 10
)
(
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Control
	input  wire logic             start_in,
	input  wire logic             run_in,
	input  wire logic [OFS_W-1:0] size_in,
	// Progress
	output logic                  byte_done_out,
	output logic [OFS_W-1:0]      offset_out
);
	logic active;

	// No byte moves while the block withholds run
	assign byte_done_out = active & run_in;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			active     <= 1'b0;
			offset_out <= '0;
		end
		else if (start_in)
		begin
			active     <= 1'b1;
			offset_out <= '0;
		end
		else if (byte_done_out)
		begin
			offset_out <= offset_out + 1'b1;
			active     <= (offset_out != size_in - 1'b1);
		end
	end
endmodule : dmacf_mover

// File: tb_dmacf_top.sv
module tb_dmacf_top
	import dmacf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        cfg_wr;
	dmacf_sfr_s  sfr;
	logic [2:0]  sel;
	logic [7:0]  cfg_d, rdata, cf, d, a;
	logic [6:0]  done, start, en, run, firq, hirq;
	logic [69:0] offs, sizes;
	logic [9:0]  sz;
	logic [31:0] seed = 32'hB286;
	int          mismatches, checks;

	dmacf_top DUT (.clock_in(clk), .rst_n_in(rst_n), .ce_in(ce), .sfr_in(sfr),
		.sfr_rdata_out(rdata), .cfg_wr_in(cfg_wr), .chan_select_field_in(sel),
		.cfg_wdata_in(cfg_d), .byte_done_in(done), .chan_byte_offset_in(offs),
		.chan_transfer_size_in(sizes), .chan_enable_out(en), .chan_run_out(run),
		.full_irq_out(firq), .half_irq_out(hirq));

	for (genvar g = 0; g < 7; g++)
	begin : g_mover
		dmacf_mover u_mover (.clock_in(clk), .rst_n_in(rst_n), .start_in(start[g]),
			.run_in(run[g]), .size_in(sizes[g*10+:10]), .byte_done_out(done[g]),
			.offset_out(offs[g*10+:10]));
	end

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Odd sizes round the midpoint up
	function automatic logic [9:0] half_tgt(input logic [9:0] s);
		if (s[0])
			return s / 10'd2 + 10'd1;
		return s / 10'd2;
	endfunction : half_tgt

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] pg, input logic [7:0] ad,
		input logic [7:0] wd);
		@(posedge clk);
		#1 sfr = '{pg, ad, w, ~w, wd};
		@(posedge clk);
		#1 sfr = '0;
	endtask : bus

	task automatic cfg(input logic [2:0] s, input logic [7:0] wd);
		@(posedge clk);
		#1 {cfg_wr, sel, cfg_d} = {1'b1, s, wd};
		@(posedge clk);
		#1 cfg_wr = 1'b0;
	endtask : cfg

	task automatic wait_stop(input int ch);
		for (int i = 0; i < 80; i++)
		begin
			@(posedge clk);
			#1;
			if (!run[ch])
				break;
		end
	endtask : wait_stop

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n, cfg_wr, sel, cfg_d, start, sizes} = '0;
		sfr = '0;
		ce = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 8'hD2; i <= 8'hD5; i++)
		begin
			bus(1'b0, 8'h02, 8'(i), 8'h00);
			check(rdata, 8'h00);
		end
		bus(1'b1, 8'h03, 8'hD2, 8'h7F);
		bus(1'b0, 8'h02, 8'hD2, 8'h00);
		check(rdata, 8'h00);
		$display("test reset and decode done");
		repeat (12)
		begin
			d = rnd();
			a = 8'hD2 + 8'(rnd() % 8'd3);
			bus(1'b1, 8'h02, a, d);
			bus(1'b0, 8'h02, a, 8'h00);
			check(rdata, d & 8'h7F);
		end
		bus(1'b1, 8'h02, 8'hD3, 8'h00);
		bus(1'b1, 8'h02, 8'hD4, 8'h00);
		bus(1'b1, 8'h02, 8'hD2, 8'hFF);
		check({1'b0, en}, 8'h7F);
		$display("test register access done");
		for (int ch = 0; ch < 7; ch++)
		begin
			sz = 10'd4 + 10'(rnd() % 32);
			sizes[ch*10+:10] = sz;
			cf = rnd() & 8'hC0;
			cfg(3'(ch), cf);
			cfg(3'h7, cf ^ 8'hC0);
			@(posedge clk);
			#1 start[ch] = 1'b1;
			@(posedge clk);
			#1 start[ch] = 1'b0;
			wait_stop(ch);
			check(offs[ch*10+:8], 8'(half_tgt(sz) + 10'd1));
			repeat (4) @(posedge clk);
			#1;
			check({1'b0, run}, 8'h7F & ~(8'h01 << ch));
			check({1'b0, hirq}, cf[6] ? 8'h01 << ch : 8'h00);
			bus(1'b0, 8'h02, 8'hD4, 8'h00);
			check(rdata, 8'h01 << ch);
			bus(1'b1, 8'h02, 8'hD4, 8'h00);
			wait_stop(ch);
			check(offs[ch*10+:8], sz[7:0]);
			check({1'b0, firq}, cf[7] ? 8'h01 << ch : 8'h00);
			bus(1'b0, 8'h02, 8'hD3, 8'h00);
			check(rdata, 8'h01 << ch);
			bus(1'b1, 8'h02, 8'hD3, 8'h00);
			check({1'b0, run}, 8'h7F);
		end
		$display("test transfers done");
		// Size 2 puts the midpoint byte on the same edge as the clear
		sizes[9:0] = 10'd2;
		@(posedge clk);
		#1 start[0] = 1'b1;
		@(posedge clk);
		#1 start[0] = 1'b0;
		bus(1'b1, 8'h02, 8'hD4, 8'h00);
		bus(1'b0, 8'h02, 8'hD4, 8'h00);
		check(rdata, 8'h01);
		ce = 1'b0;
		bus(1'b1, 8'h02, 8'hD2, 8'h00);
		bus(1'b1, 8'h02, 8'hD4, 8'h00);
		bus(1'b0, 8'h02, 8'hD2, 8'h00);
		check(rdata, 8'h01);
		ce = 1'b1;
		bus(1'b0, 8'h02, 8'hD4, 8'h00);
		check(rdata, 8'h01);
		bus(1'b0, 8'h02, 8'hD2, 8'h00);
		check(rdata, 8'h7F);
		@(posedge clk);
		#1 rst_n = 1'b0;
		@(posedge clk);
		#1 rst_n = 1'b1;
		check({1'b0, run | en | firq | hirq}, 8'h00);
		bus(1'b0, 8'h02, 8'hD3, 8'h00);
		check(rdata, 8'h00);
		bus(1'b0, 8'h02, 8'hD4, 8'h00);
		check(rdata, 8'h00);
		$display("test collision, freeze and reset done");
		tally_and_finish();
	end

	// Generous bound: the tests need a few hundred of the 10000 cycles allowed here
	initial
	begin
		#400000;
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_dmacf_top
